// >>> shared/vstc_pkg.sv
// Shared constants and types for the strobe transceiver control block
package vstc_pkg;
    localparam int  ADDR_W        = 31;
    localparam int  DATA_W        = 32;
    localparam logic XCVR_OUT     = 1'b1;
    localparam logic XCVR_IN      = 1'b0;
    localparam logic [1:0] DS_NONE = 2'h3;
    localparam logic [1:0] DS_BOTH = 2'h0;
    localparam logic [1:0] DS_UPPER = 2'h1;
    localparam logic [1:0] DS_LOWER = 2'h2;
    localparam logic [2:0] SIZE_1 = 3'h1;
    localparam logic [2:0] SIZE_2 = 3'h2;
    localparam logic [2:0] SIZE_3 = 3'h3;
    localparam logic [2:0] SIZE_4 = 3'h4;
    localparam int  MBLT_BIT      = 32;
    localparam logic [3:0] RETRY_BACKOFF = 4'h8;
    localparam logic [3:0] TIMEOUT_CYC = 4'hF;
    typedef enum logic [1:0] {
        VSTC_XFER_NONE,
        VSTC_XFER_READ,
        VSTC_XFER_WRITE
    } vstc_xfer_t;
endpackage : vstc_pkg

// >>> shared/vstc_if.sv
// Bus wires between the documented device and the far party
`timescale 1ns/1ps
interface vstc_if;
    import vstc_pkg::*;
    logic [1:0]        ds_n_dev;
    logic              ds_oe_dev;
    logic [1:0]        ds_n_far;
    logic              ds_oe_far;
    logic              lw_n_dev;
    logic              lw_oe_dev;
    logic              lw_n_far;
    logic              lw_oe_far;
    logic [ADDR_W-1:0] addr_dev;
    logic              addr_oe_dev;
    logic [ADDR_W-1:0] addr_far;
    logic              addr_oe_far;
    logic [DATA_W-1:0] data_dev;
    logic              data_oe_dev;
    logic [DATA_W-1:0] data_far;
    logic              data_oe_far;
    logic              write_n_dev;
    logic              write_n_far;
    logic              as_n_dev;
    logic              as_n_far;
    logic              dtack_n_far;
    logic              dtack_n_dev;
    logic              dtack_oe_dev;
    logic              rr_n_dev;
    logic              rr_oe_dev;
    logic              rr_n_far;
    logic              rr_oe_far;
    logic [1:0]        bus_data_strobe;
    logic              bus_longword_ind;
    logic [ADDR_W-1:0] bus_addr_lines;
    logic [DATA_W-1:0] bus_data;
    logic              bus_write_n;
    logic              bus_as_n;
    logic              bus_dtack_n;
    logic              bus_rmw_indicator;
    assign bus_data_strobe   = ds_oe_dev ? ds_n_dev : (ds_oe_far ? ds_n_far : DS_NONE);
    assign bus_longword_ind  = (lw_oe_dev ? lw_n_dev : 1'b1) & (lw_oe_far ? lw_n_far : 1'b1);
    assign bus_addr_lines    = addr_oe_dev ? addr_dev : (addr_oe_far ? addr_far : '1);
    assign bus_data          = data_oe_dev ? data_dev : (data_oe_far ? data_far : '1);
    assign bus_write_n       = ds_oe_dev ? write_n_dev : (ds_oe_far ? write_n_far : 1'b1);
    assign bus_as_n          = ds_oe_dev ? as_n_dev : (ds_oe_far ? as_n_far : 1'b1);
    assign bus_dtack_n       = dtack_n_far & (dtack_oe_dev ? dtack_n_dev : 1'b1);
    assign bus_rmw_indicator = (rr_oe_dev ? rr_n_dev : 1'b1) & (rr_oe_far ? rr_n_far : 1'b1);
    modport dev (
        output ds_n_dev, ds_oe_dev, lw_n_dev, lw_oe_dev, addr_dev, addr_oe_dev,
        output data_dev, data_oe_dev, write_n_dev, as_n_dev, dtack_n_dev, dtack_oe_dev,
        output rr_n_dev, rr_oe_dev,
        input  bus_data_strobe, bus_longword_ind, bus_addr_lines, bus_data,
        input  bus_write_n, bus_as_n, bus_dtack_n, bus_rmw_indicator
    );
    modport far (
        output ds_n_far, ds_oe_far, lw_n_far, lw_oe_far, addr_far, addr_oe_far,
        output data_far, data_oe_far, write_n_far, as_n_far, dtack_n_far,
        output rr_n_far, rr_oe_far,
        input  bus_data_strobe, bus_longword_ind, bus_addr_lines, bus_data,
        input  bus_write_n, bus_as_n, bus_dtack_n, bus_rmw_indicator
    );
endinterface : vstc_if

// >>> hw/vstc_dev.sv
// Documented device end: master and slave strobe handling, transceiver directions
//
// What this block does
// - Data transceiver direction follows read, write, isolation
// - Write data valid before strobes fall
// - Read strobes request data; slave supplies it
// - Size coded by longword, strobes, address bit 1
// - Longword line carries data bit 32 in MBLT
// - Strobe transceivers outward only while master
// - Retry ends attempt; transfer repeated after backoff, dropped if isolate is set when backoff ends
// - Master asserts shared pin for read-modify-write
// - Address transceiver direction matches master, slave, isolation
`timescale 1ns/1ps
module vstc_dev
    import vstc_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    vstc_if.dev                     bus,
    input  wire logic               isolate,
    input  wire logic               pin_is_rmw,
    input  wire logic               req_valid,
    input  wire vstc_xfer_t         req_kind,
    input  wire logic [2:0]         req_size,
    input  wire logic               req_mblt,
    input  wire logic               req_rmw,
    input  wire logic [ADDR_W-1:0]  req_addr,
    input  wire logic [DATA_W:0]    req_wdata,
    input  wire logic [DATA_W:0]    slv_rdata,
    output logic                    req_busy,
    output logic                    rsp_done,
    output logic                    rsp_retry,
    output logic [DATA_W:0]         rsp_rdata,
    output logic                    slv_hit,
    output logic                    slv_write,
    output logic [DATA_W:0]         slv_wdata,
    output logic                    data_xcvr_dir,
    output logic                    strobe_xcvr_dir,
    output logic                    addr_xcvr_dir
);
    import vstc_pkg::*;

    typedef enum logic [2:0] {
        VSTC_IDLE, VSTC_ADDR, VSTC_STRB, VSTC_WAIT, VSTC_BACKOFF, VSTC_SLAVE
    } vstc_state_t;

    vstc_state_t        st_q, st_d;
    vstc_xfer_t         kind_q, kind_d;
    logic [2:0]         size_q, size_d;
    logic               mblt_q, mblt_d, rmw_q, rmw_d;
    logic [ADDR_W-1:0]  addr_q, addr_d;
    logic [DATA_W:0]    wdata_q, wdata_d, rdata_q, rdata_d, swdata_q, swdata_d;
    logic [3:0]         cnt_q, cnt_d;
    logic               done_q, done_d, retry_q, retry_d, hit_q, hit_d, swr_q, swr_d;
    logic               ddir_q, ddir_d, sdir_q, sdir_d, adir_q, adir_d;
    logic               busy_q, busy_d;

    function automatic logic [1:0] size_to_ds(input logic [2:0] sz, input logic a1);
        logic [1:0] r;
        r = DS_BOTH;
        unique case (sz)
            SIZE_1:  r = a1 ? DS_LOWER : DS_UPPER;
            SIZE_2:  r = DS_BOTH;
            SIZE_3:  r = a1 ? DS_LOWER : DS_UPPER;
            default: r = DS_BOTH;
        endcase
        return r;
    endfunction : size_to_ds

    wire master    = (st_q == VSTC_ADDR) || (st_q == VSTC_STRB) || (st_q == VSTC_WAIT);
    wire is_write  = (kind_q == VSTC_XFER_WRITE);
    wire retry_in  = !pin_is_rmw && !bus.bus_rmw_indicator;
    wire ds_any    = (bus.bus_data_strobe != DS_NONE);

    always_comb begin
        st_d = st_q; kind_d = kind_q; size_d = size_q; mblt_d = mblt_q; rmw_d = rmw_q;
        addr_d = addr_q; wdata_d = wdata_q; rdata_d = rdata_q; swdata_d = swdata_q;
        cnt_d = cnt_q; done_d = 1'b0; retry_d = 1'b0; hit_d = 1'b0; swr_d = swr_q;
        unique case (st_q)
            VSTC_IDLE: begin
                if (req_valid && !isolate && req_kind != VSTC_XFER_NONE) begin
                    kind_d = req_kind; size_d = req_size; mblt_d = req_mblt;
                    rmw_d = req_rmw && pin_is_rmw; addr_d = req_addr; wdata_d = req_wdata;
                    st_d = VSTC_ADDR;
                end else if (!isolate && !bus.bus_as_n && ds_any) begin
                    st_d = VSTC_SLAVE;
                    hit_d = 1'b1;
                    swr_d = !bus.bus_write_n;
                    swdata_d = {!bus.bus_longword_ind, bus.bus_data};
                end
            end
            VSTC_ADDR: st_d = VSTC_STRB;
            VSTC_STRB: st_d = VSTC_WAIT;
            VSTC_WAIT: begin
                if (retry_in) begin
                    retry_d = 1'b1;
                    cnt_d = RETRY_BACKOFF;
                    st_d = VSTC_BACKOFF;
                end else if (!bus.bus_dtack_n) begin
                    rdata_d = {mblt_q ? !bus.bus_longword_ind : 1'b0, bus.bus_data};
                    done_d = 1'b1;
                    st_d = VSTC_IDLE;
                end
            end
            VSTC_BACKOFF: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    st_d = isolate ? VSTC_IDLE : VSTC_ADDR;
                end
            end
            VSTC_SLAVE: begin
                if (bus.bus_as_n || !ds_any) begin
                    st_d = VSTC_IDLE;
                end
            end
            default: st_d = VSTC_IDLE;
        endcase
    end

    always_comb begin
        ddir_d = XCVR_IN;
        sdir_d = XCVR_IN;
        adir_d = XCVR_IN;
        busy_d = (st_d != VSTC_IDLE) && (st_d != VSTC_SLAVE);
        if (!isolate) begin
            if (st_d == VSTC_ADDR || st_d == VSTC_STRB || st_d == VSTC_WAIT) begin
                sdir_d = XCVR_OUT;
                adir_d = XCVR_OUT;
                ddir_d = (kind_d == VSTC_XFER_WRITE) ? XCVR_OUT : XCVR_IN;
            end else if (st_d == VSTC_SLAVE) begin
                ddir_d = swr_d ? XCVR_IN : XCVR_OUT;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= VSTC_IDLE; kind_q <= VSTC_XFER_NONE; size_q <= SIZE_4;
            mblt_q <= 1'b0; rmw_q <= 1'b0; addr_q <= '0; wdata_q <= '0; rdata_q <= '0;
            swdata_q <= '0; cnt_q <= '0; done_q <= 1'b0; retry_q <= 1'b0; hit_q <= 1'b0;
            swr_q <= 1'b0; ddir_q <= XCVR_IN; sdir_q <= XCVR_IN; adir_q <= XCVR_IN;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d; kind_q <= kind_d; size_q <= size_d; mblt_q <= mblt_d;
            rmw_q <= rmw_d; addr_q <= addr_d; wdata_q <= wdata_d; rdata_q <= rdata_d;
            swdata_q <= swdata_d; cnt_q <= cnt_d; done_q <= done_d; retry_q <= retry_d;
            hit_q <= hit_d; swr_q <= swr_d; ddir_q <= ddir_d; sdir_q <= sdir_d;
            adir_q <= adir_d; busy_q <= busy_d;
        end
    end

    assign req_busy        = busy_q;
    assign rsp_done        = done_q;
    assign rsp_retry       = retry_q;
    assign rsp_rdata       = rdata_q;
    assign slv_hit         = hit_q;
    assign slv_write       = swr_q;
    assign slv_wdata       = swdata_q;
    assign data_xcvr_dir   = ddir_q;
    assign strobe_xcvr_dir = sdir_q;
    assign addr_xcvr_dir   = adir_q;

    assign bus.ds_oe_dev    = master && sdir_q;
    assign bus.ds_n_dev     = (st_q == VSTC_STRB || st_q == VSTC_WAIT) ?
                              size_to_ds(size_q, addr_q[0]) : DS_NONE;
    assign bus.as_n_dev     = !master;
    assign bus.write_n_dev  = !is_write;
    assign bus.addr_oe_dev  = master && adir_q;
    assign bus.addr_dev     = addr_q;
    assign bus.lw_oe_dev    = (master && adir_q) || (st_q == VSTC_SLAVE && !swr_q && mblt_q);
    assign bus.lw_n_dev     = (st_q == VSTC_SLAVE) ? !slv_rdata[MBLT_BIT] :
                              (mblt_q ? !wdata_q[MBLT_BIT] : (size_q != SIZE_4 && size_q != SIZE_3));
    assign bus.data_oe_dev  = (master && is_write && ddir_q) || (st_q == VSTC_SLAVE && !swr_q);
    assign bus.data_dev     = (st_q == VSTC_SLAVE) ? slv_rdata[DATA_W-1:0] : wdata_q[DATA_W-1:0];
    assign bus.dtack_oe_dev = (st_q == VSTC_SLAVE);
    assign bus.dtack_n_dev  = !(st_q == VSTC_SLAVE);
    assign bus.rr_oe_dev    = pin_is_rmw && master && rmw_q;
    assign bus.rr_n_dev     = 1'b0;
endmodule : vstc_dev

// >>> hw/vstc_far.sv
// Far party end: simple bus master or slave on the backplane
`timescale 1ns/1ps
module vstc_far
    import vstc_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    vstc_if.far                     bus,
    input  wire logic               pin_is_rmw,
    input  wire logic               mst_valid,
    input  wire logic               mst_write,
    input  wire logic [1:0]         mst_ds_n,
    input  wire logic               mst_lw_n,
    input  wire logic               mst_rmw,
    input  wire logic [ADDR_W-1:0]  mst_addr,
    input  wire logic [DATA_W-1:0]  mst_wdata,
    input  wire logic               slv_retry,
    input  wire logic [DATA_W-1:0]  slv_rdata,
    output logic                    mst_done,
    output logic [DATA_W-1:0]       mst_rdata,
    output logic                    slv_hit,
    output logic [DATA_W:0]         slv_wdata
);
    import vstc_pkg::*;

    typedef enum logic [1:0] {VSTCF_IDLE, VSTCF_ADDR, VSTCF_STRB, VSTCF_SLV} vstcf_state_t;

    vstcf_state_t      st_q, st_d;
    logic              wr_q, wr_d, done_q, done_d, hit_q, hit_d, rmw_q, rmw_d, lw_q, lw_d;
    logic [1:0]        ds_q, ds_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
    logic [DATA_W:0]   sw_q, sw_d;

    wire slv_sel = !bus.bus_as_n && (bus.bus_data_strobe != DS_NONE) && !bus.ds_oe_far;

    always_comb begin
        st_d = st_q; wr_d = wr_q; ds_d = ds_q; addr_d = addr_q; wd_d = wd_q; rd_d = rd_q;
        rmw_d = rmw_q; lw_d = lw_q; sw_d = sw_q; done_d = 1'b0; hit_d = 1'b0;
        unique case (st_q)
            VSTCF_IDLE: begin
                if (mst_valid && bus.bus_as_n) begin
                    wr_d = mst_write; ds_d = mst_ds_n; addr_d = mst_addr; wd_d = mst_wdata;
                    lw_d = mst_lw_n; rmw_d = mst_rmw && pin_is_rmw;
                    st_d = VSTCF_ADDR;
                end else if (slv_sel) begin
                    hit_d = 1'b1;
                    sw_d = {!bus.bus_longword_ind, bus.bus_data};
                    st_d = VSTCF_SLV;
                end
            end
            VSTCF_ADDR: st_d = VSTCF_STRB;
            VSTCF_STRB: begin
                if (!bus.bus_dtack_n) begin
                    rd_d = bus.bus_data;
                    done_d = 1'b1;
                    st_d = VSTCF_IDLE;
                end
            end
            VSTCF_SLV: begin
                if (bus.bus_as_n || bus.bus_data_strobe == DS_NONE) begin
                    st_d = VSTCF_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= VSTCF_IDLE; wr_q <= 1'b0; ds_q <= DS_NONE; addr_q <= '0; wd_q <= '0;
            rd_q <= '0; rmw_q <= 1'b0; lw_q <= 1'b1; sw_q <= '0; done_q <= 1'b0; hit_q <= 1'b0;
        end else begin
            st_q <= st_d; wr_q <= wr_d; ds_q <= ds_d; addr_q <= addr_d; wd_q <= wd_d;
            rd_q <= rd_d; rmw_q <= rmw_d; lw_q <= lw_d; sw_q <= sw_d; done_q <= done_d;
            hit_q <= hit_d;
        end
    end

    wire mst = (st_q == VSTCF_ADDR) || (st_q == VSTCF_STRB);
    assign mst_done        = done_q;
    assign mst_rdata       = rd_q;
    assign slv_hit         = hit_q;
    assign slv_wdata       = sw_q;
    assign bus.ds_oe_far   = mst;
    assign bus.ds_n_far    = (st_q == VSTCF_STRB) ? ds_q : DS_NONE;
    assign bus.as_n_far    = !mst;
    assign bus.write_n_far = !wr_q;
    assign bus.addr_oe_far = mst;
    assign bus.addr_far    = addr_q;
    assign bus.lw_oe_far   = mst;
    assign bus.lw_n_far    = lw_q;
    assign bus.data_oe_far = (mst && wr_q) || (st_q == VSTCF_SLV && bus.bus_write_n);
    assign bus.data_far    = (st_q == VSTCF_SLV) ? slv_rdata : wd_q;
    assign bus.dtack_n_far = !(st_q == VSTCF_SLV && !(slv_retry && !pin_is_rmw));
    assign bus.rr_oe_far   = (!pin_is_rmw && st_q == VSTCF_SLV && slv_retry) || (mst && rmw_q);
    assign bus.rr_n_far    = 1'b0;
endmodule : vstc_far

// >>> dv/vstc_chk.sv
// Concurrent checks on the bus wires between the two ends
`timescale 1ns/1ps
module vstc_chk
    import vstc_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic              pin_is_rmw,
    input wire logic              isolate,
    input wire logic [1:0]        ds_n_dev,
    input wire logic              ds_oe_dev,
    input wire logic              as_n_dev,
    input wire logic              write_n_dev,
    input wire logic [DATA_W-1:0] data_dev,
    input wire logic              data_oe_dev,
    input wire logic              addr_oe_dev,
    input wire logic              rr_oe_dev,
    input wire logic              dtack_oe_dev,
    input wire logic              bus_rmw_indicator,
    input wire logic              bus_dtack_n,
    input wire logic              bus_write_n,
    input wire logic              bus_as_n,
    input wire logic              data_xcvr_dir,
    input wire logic              strobe_xcvr_dir,
    input wire logic              addr_xcvr_dir
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire mst_ds = ds_oe_dev && (ds_n_dev != DS_NONE);
    a_write_data_valid: assert property (mst_ds && !write_n_dev |-> data_oe_dev && $stable(data_dev))
        else $error("write data not steady at strobe");
    a_read_dir_in: assert property (mst_ds && write_n_dev |-> data_xcvr_dir == XCVR_IN && !data_oe_dev)
        else $error("data path not inward on read");
    a_write_dir_out: assert property (data_oe_dev && ds_oe_dev |-> data_xcvr_dir == XCVR_OUT)
        else $error("data path not outward on write");
    a_strobe_out_master: assert property (!as_n_dev |-> strobe_xcvr_dir == XCVR_OUT)
        else $error("strobes inward while master");
    a_strobe_in_other: assert property (strobe_xcvr_dir == XCVR_OUT |-> ds_oe_dev || $past(ds_oe_dev))
        else $error("strobes outward while not master");
    a_addr_dir_match: assert property (addr_oe_dev |-> addr_xcvr_dir == XCVR_OUT && strobe_xcvr_dir == XCVR_OUT)
        else $error("address path direction mismatch");
    a_isolate_all_in: assert property (isolate && !ds_oe_dev |=> !ds_oe_dev && data_xcvr_dir == XCVR_IN
        && strobe_xcvr_dir == XCVR_IN && addr_xcvr_dir == XCVR_IN)
        else $error("transceiver outward during isolation");
    a_retry_reissue: assert property (!pin_is_rmw && mst_ds && !bus_rmw_indicator
        |-> ##[1:16] (ds_oe_dev && !as_n_dev && ds_n_dev == DS_NONE))
        else $error("retried cycle not reissued");
    a_pin_one_meaning: assert property (!pin_is_rmw |-> !rr_oe_dev)
        else $error("shared pin driven in retry mode");
    a_slave_read_data: assert property (!ds_oe_dev && !bus_as_n && dtack_oe_dev && !bus_dtack_n && bus_write_n
        |-> data_oe_dev)
        else $error("slave read acknowledged without data");
    c_write: cover property (mst_ds && !write_n_dev);
    c_read: cover property (mst_ds && write_n_dev);
    c_retry: cover property (!pin_is_rmw && mst_ds && !bus_rmw_indicator);
    c_slave: cover property (dtack_oe_dev && !bus_dtack_n);
endmodule : vstc_chk

// >>> dv/vstc_test.sv
// Self-checking bench joining the device end and the far end
`timescale 1ns/1ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin fails++; $display("BAD %0t %s", $time, m); end end
module vstc_test;
    import vstc_pkg::*;
    logic              sys_clk, rst_n, isolate, pin_is_rmw, req_valid, req_mblt, req_rmw, hit;
    vstc_xfer_t        req_kind;
    logic [2:0]        req_size, sz;
    logic [ADDR_W-1:0] req_addr, mst_addr;
    logic [DATA_W:0]   req_wdata, slv_rdata, rsp_rdata, slv_wdata, f_wdata;
    logic              req_busy, rsp_done, rsp_retry, slv_hit, slv_write, ddir, sdir, adir;
    logic              mst_valid, mst_write, mst_lw_n, mst_rmw, f_retry, mst_done, f_hit, c_lw, c_rmw, c_ddir, c_sdir;
    logic [1:0]        mst_ds_n, c_ds;
    logic [DATA_W-1:0] mst_wdata, f_rdata, mst_rdata, c_data;
    int                fails, check_count, retries, f_hits;
    vstc_if bus_i ();
    vstc_dev vstc_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_i.dev), .isolate(isolate),
        .pin_is_rmw(pin_is_rmw), .req_valid(req_valid), .req_kind(req_kind), .req_size(req_size),
        .req_mblt(req_mblt), .req_rmw(req_rmw), .req_addr(req_addr), .req_wdata(req_wdata), .slv_rdata(slv_rdata),
        .req_busy(req_busy), .rsp_done(rsp_done), .rsp_retry(rsp_retry), .rsp_rdata(rsp_rdata), .slv_hit(slv_hit),
        .slv_write(slv_write), .slv_wdata(slv_wdata), .data_xcvr_dir(ddir), .strobe_xcvr_dir(sdir),
        .addr_xcvr_dir(adir));
    vstc_far vstc_far_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_i.far), .pin_is_rmw(pin_is_rmw),
        .mst_valid(mst_valid), .mst_write(mst_write), .mst_ds_n(mst_ds_n), .mst_lw_n(mst_lw_n), .mst_rmw(mst_rmw),
        .mst_addr(mst_addr), .mst_wdata(mst_wdata), .slv_retry(f_retry), .slv_rdata(f_rdata), .mst_done(mst_done),
        .mst_rdata(mst_rdata), .slv_hit(f_hit), .slv_wdata(f_wdata));
    vstc_chk vstc_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .pin_is_rmw(pin_is_rmw), .isolate(isolate),
        .ds_n_dev(bus_i.ds_n_dev), .ds_oe_dev(bus_i.ds_oe_dev), .as_n_dev(bus_i.as_n_dev),
        .write_n_dev(bus_i.write_n_dev), .data_dev(bus_i.data_dev), .data_oe_dev(bus_i.data_oe_dev),
        .addr_oe_dev(bus_i.addr_oe_dev), .rr_oe_dev(bus_i.rr_oe_dev), .dtack_oe_dev(bus_i.dtack_oe_dev),
        .bus_rmw_indicator(bus_i.bus_rmw_indicator), .bus_dtack_n(bus_i.bus_dtack_n), .bus_as_n(bus_i.bus_as_n),
        .bus_write_n(bus_i.bus_write_n), .data_xcvr_dir(ddir), .strobe_xcvr_dir(sdir), .addr_xcvr_dir(adir));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // Device as master; captures the wires at the first strobe cycle
    task automatic dev_xfer(input vstc_xfer_t k, input logic [2:0] s, input logic mb, input logic [ADDR_W-1:0] a,
                            input logic [DATA_W:0] wd);
        logic seen;
        logic done;
        seen = 1'b0;
        done = 1'b0;
        retries = 0;
        f_hits = 0;
        req_kind = k;
        req_size = s;
        req_mblt = mb;
        req_addr = a;
        req_wdata = wd;
        req_valid = 1'b1;
        for (int n = 0; n < 300 && !done; n++) begin
            tick();
            if (req_busy === 1'b1) req_valid = 1'b0;
            if (!seen && bus_i.ds_oe_dev === 1'b1 && bus_i.bus_data_strobe !== DS_NONE) begin
                seen = 1'b1;
                c_ds = bus_i.bus_data_strobe;
                c_lw = bus_i.bus_longword_ind;
                c_data = bus_i.bus_data;
                c_rmw = bus_i.bus_rmw_indicator;
                c_ddir = ddir;
                c_sdir = sdir;
            end
            if (rsp_retry === 1'b1) begin
                retries++;
                f_retry = 1'b0;
            end
            if (f_hit === 1'b1) f_hits++;
            done = (rsp_done === 1'b1);
        end
        if (!done) begin
            fails++;
            test_done();
        end
    endtask : dev_xfer
    // Far end as master, device as slave
    task automatic far_xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        logic done;
        done = 1'b0;
        hit = 1'b0;
        mst_write = w;
        mst_addr = a;
        mst_wdata = wd;
        mst_valid = 1'b1;
        for (int n = 0; n < 300 && !done; n++) begin
            tick();
            if (bus_i.bus_as_n === 1'b0) mst_valid = 1'b0;
            if (bus_i.bus_data_strobe !== DS_NONE) c_sdir = sdir;
            if (slv_hit === 1'b1) hit = 1'b1;
            done = (mst_done === 1'b1);
        end
        if (!done) begin
            fails++;
            test_done();
        end
    endtask : far_xfer
    initial begin
        {rst_n, isolate, pin_is_rmw, req_valid, req_mblt, req_rmw, mst_valid, mst_write, mst_rmw, f_retry} = '0;
        {mst_lw_n, hit} = '0;
        req_kind = VSTC_XFER_NONE;
        {req_size, sz} = {SIZE_4, SIZE_4};
        {req_addr, mst_addr, req_wdata, mst_wdata} = '0;
        mst_ds_n = DS_BOTH;
        f_rdata = 32'hC3C3_5A5A;
        slv_rdata = {1'b0, 32'h5A5A_C3C3};
        fails = 0;
        check_count = 0;
        retries = 0;
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        `CHK({ddir, sdir, adir}, {3{XCVR_IN}}, "directions after reset")
        for (int i = 0; i < 8; i++) begin
            sz = 3'(i / 2 + 1);
            dev_xfer(VSTC_XFER_WRITE, sz, 1'b0, {30'h0A5, i[0]}, {1'b0, 32'h1234_5670 + 32'(i)});
            `CHK(c_ds, (sz[0] ? (i[0] ? DS_LOWER : DS_UPPER) : DS_BOTH), "strobe code")
            `CHK(c_lw, (sz < SIZE_3), "longword code")
            `CHK(c_data, 32'h1234_5670 + 32'(i), "write data at strobe")
            `CHK(f_wdata[31:0], 32'h1234_5670 + 32'(i), "far slave data")
            `CHK(c_sdir, XCVR_OUT, "strobe direction as master")
            `CHK(f_hits, 1, "far selected once")
        end
        dev_xfer(VSTC_XFER_READ, SIZE_4, 1'b0, 31'h0000_0100, '0);
        `CHK(rsp_rdata[31:0], 32'hC3C3_5A5A, "read data")
        `CHK(c_ddir, XCVR_IN, "data direction on read")
        for (int b = 0; b < 2; b++) begin
            dev_xfer(VSTC_XFER_WRITE, SIZE_4, 1'b1, 31'h0000_0300, {b[0], 32'h0F0F_0F0F});
            `CHK(c_lw, ~b[0], "longword carries bit 32")
            `CHK(f_wdata[32], b[0], "far bit 32")
        end
        f_retry = 1'b1;
        dev_xfer(VSTC_XFER_WRITE, SIZE_4, 1'b0, 31'h0000_0400, {1'b0, 32'hA5A5_0001});
        `CHK(retries, 1, "one retry then repeat")
        `CHK(f_hits, 2, "far saw attempt and repeat")
        `CHK(f_wdata[31:0], 32'hA5A5_0001, "repeated write data")
        pin_is_rmw = 1'b1;
        req_rmw = 1'b1;
        f_retry = 1'b1;
        dev_xfer(VSTC_XFER_READ, SIZE_4, 1'b0, 31'h0000_0500, '0);
        `CHK(c_rmw, 1'b0, "rmw indicator asserted")
        `CHK(retries, 0, "retry ignored in rmw mode")
        {pin_is_rmw, req_rmw, f_retry} = '0;
        far_xfer(1'b1, 31'h0000_0200, 32'h8765_4321);
        `CHK({hit, slv_write, slv_wdata[31:0]}, {2'h3, 32'h8765_4321}, "slave write")
        `CHK(c_sdir, XCVR_IN, "strobe direction as slave")
        far_xfer(1'b0, 31'h0000_0204, '0);
        `CHK(mst_rdata, 32'h5A5A_C3C3, "slave read data")
        isolate = 1'b1;
        req_kind = VSTC_XFER_WRITE;
        req_valid = 1'b1;
        repeat (10) tick();
        `CHK(req_busy, 1'b0, "start during isolation")
        `CHK({ddir, sdir, adir}, {3{XCVR_IN}}, "directions in isolation")
        isolate = 1'b0;
        dev_xfer(VSTC_XFER_WRITE, SIZE_2, 1'b0, 31'h0000_0600, {1'b0, 32'h0000_BEEF});
        `CHK(f_wdata[31:0], 32'h0000_BEEF, "write after isolation")
        test_done();
    end
endmodule : vstc_test
